// ===== hdl/sweep_recording_control.sv
// Overview of operation
// [R01] Run starts storing samples, storing continues until a stop command.
// [R02] Stop is manual, or trigger-generated when sweep storage is selected.
// [R03] Pause while idle gives standby: digitizing continues, nothing stored.
// [R04] Pause while recording holds storage; run resumes, stop finishes.
// [R05] All channels share sample rate, sweep length, pre/post lengths.
// [R06] Continuous stores every sample; sweep stores only sweep samples.
// [R07] Dual stores sweep data and reduced-rate data between sweeps.
// [R08] A sweep has fixed length; a trigger places its start and end.
// [R09] Sample codes go to consecutive memory locations.
// [R10] Memory splits into segments holding several sweeps.
// [R11] After a segment's last location, writing wraps to its first.
// [R12] Segment ring filling stops only when the sweep must end.
// [R13] A stopped sweep becomes readable and is moved to the recording.
// [R14] Standby press toggles state; holding over four seconds powers off.
// [R15] After trigger, storage continues until the post-trigger delay ends.
// [R16] Pre-trigger is segment minus delay; long delay gives post only.
// [R17] Write pointer advances per sample while storing, holds when paused.
// [R18] A sweep-complete flag tells software the segment is ready.
`default_nettype none
module sweep_recording_control
  import sweep_rec_pkg::*;
#(
  parameter longint HOLD_CYC = HOLD_OFF_CYC,
  parameter int RATE_DIV = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cmdRun,
  input wire logic cmdStop,
  input wire logic cmdPause,
  input wire logic trigger,
  input wire logic sampleTick,
  input wire logic [SAMPLE_W-1:0] sampleData,
  input wire sweep_rec_pkg::store_mode_e storeMode,
  input wire logic [DELAY_W-1:0] postDelay,
  input wire logic [SEG_SEL_W-1:0] rdSeg,
  input wire logic [SEG_ADDR_W-1:0] rdAddr,
  input wire logic sweepAck,
  input wire logic standbyBtn,
  output logic recording,
  output logic storing,
  output logic [SEG_SEL_W-1:0] curSeg,
  output logic [SEG_ADDR_W-1:0] wrPtr,
  output logic sweepDone,
  output logic [SEG_SEL_W-1:0] doneSeg,
  output logic [SEG_ADDR_W-1:0] trigPtr,
  output logic [SAMPLE_W-1:0] rdData,
  output logic contValid,
  output logic [SAMPLE_W-1:0] contData,
  output logic standbyMode,
  output logic forcePowerOff
);
  import sweep_rec_pkg::*;

  typedef struct packed {
    rec_state_e state;
    logic recording;
    logic storing;
    logic [SEG_SEL_W-1:0] curSeg;
    logic [SEG_ADDR_W-1:0] wrPtr;
    logic [DELAY_W-1:0] delayCnt;
    logic sweepDone;
    logic [SEG_SEL_W-1:0] doneSeg;
    logic [SEG_ADDR_W-1:0] trigPtr;
    logic [7:0] divCnt;
    logic contValid;
    logic [SAMPLE_W-1:0] contData;
    logic btnPrev;
    logic [39:0] holdCnt;
    logic standbyMode;
    logic forcePowerOff;
  } state_s;

  state_s r;
  state_s next_r;
  logic memWe;

  function automatic logic sweepMode(input store_mode_e m);
    sweepMode = (m == MODE_SWEEP) || (m == MODE_DUAL);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_r = r;
    next_r.contValid = 1'b0;
    memWe = 1'b0;
    if (sweepAck) begin
      next_r.sweepDone = 1'b0;
    end
    case (r.state)
      ST_IDLE: begin
        if (cmdRun) begin
          next_r.state = ST_REC; // R01
          next_r.wrPtr = PTR_RST;
        end else if (cmdPause) begin
          next_r.state = ST_STANDBY; // R03
        end
      end
      ST_STANDBY: begin
        if (cmdRun) begin
          next_r.state = ST_REC;
          next_r.wrPtr = PTR_RST;
        end else if (cmdStop) begin
          next_r.state = ST_IDLE;
        end
      end
      ST_REC, ST_POST: begin
        if (cmdStop) begin
          next_r.state = ST_IDLE; // R02
        end else if (cmdPause) begin
          next_r.state = ST_HOLD; // R04
        end else if (r.state == ST_REC && trigger &&
                     sweepMode(storeMode)) begin
          next_r.state = ST_POST; // R08
          next_r.delayCnt = postDelay; // R15 R16
          next_r.trigPtr = r.wrPtr;
        end
      end
      ST_HOLD: begin
        if (cmdRun) begin
          next_r.state = ST_REC; // R04
        end else if (cmdStop) begin
          next_r.state = ST_IDLE;
        end
      end
      default: next_r.state = ST_IDLE;
    endcase
    // Storage only in ST_REC and ST_POST; hold keeps the pointer
    if ((r.state == ST_REC || r.state == ST_POST) && !cmdStop && !cmdPause
        && sampleTick) begin
      memWe = 1'b1; // R06 R09
      next_r.wrPtr = r.wrPtr + 1'b1; // R11 R17
      if (r.state == ST_POST) begin
        if (r.delayCnt == DELAY_RST || r.delayCnt == 12'h001) begin
          // Sweep ends only here, after the delay has counted out
          next_r.state = ST_REC; // R12
          next_r.sweepDone = 1'b1; // R13 R18
          next_r.doneSeg = r.curSeg;
          next_r.curSeg = r.curSeg + 1'b1; // R10
          next_r.wrPtr = PTR_RST;
        end else begin
          next_r.delayCnt = r.delayCnt - 1'b1; // R15
        end
      end
      // Reduced-rate stream between sweeps in dual mode
      if (storeMode == MODE_DUAL && r.state == ST_REC) begin
        if (r.divCnt == 8'(RATE_DIV - 1)) begin
          next_r.divCnt = 8'h00;
          next_r.contValid = 1'b1; // R07
          next_r.contData = sampleData;
        end else begin
          next_r.divCnt = r.divCnt + 1'b1;
        end
      end
      if (storeMode == MODE_CONT) begin
        next_r.contValid = 1'b1; // R06
        next_r.contData = sampleData;
      end
    end
    if (r.state == ST_POST && trigger) begin
      next_r.trigPtr = r.trigPtr; // Retrigger during delay is ignored
    end
    next_r.recording = (next_r.state == ST_REC) ||
                       (next_r.state == ST_POST) ||
                       (next_r.state == ST_HOLD);
    next_r.storing = (next_r.state == ST_REC) || (next_r.state == ST_POST);
    // Standby button: toggle on release, power off after long hold
    next_r.btnPrev = standbyBtn;
    if (standbyBtn) begin
      if (r.holdCnt < 40'(HOLD_CYC)) begin
        next_r.holdCnt = r.holdCnt + 1'b1;
      end else begin
        next_r.forcePowerOff = 1'b1; // R14
      end
    end else begin
      next_r.holdCnt = 40'h00_0000_0000;
      if (r.btnPrev && !r.forcePowerOff) begin
        next_r.standbyMode = !r.standbyMode; // R14
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r <= '0;
      r.state <= ST_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // Single recorder with one segment pointer: every channel shares settings
  sample_mem #(.DW(SAMPLE_W), .AW(ADDR_W)) u_mem ( // R05
    .sys_clk(sys_clk),
    .wrEn(memWe),
    .wrAddr({r.curSeg, r.wrPtr}),
    .wrData(sampleData),
    .rdAddr({rdSeg, rdAddr}),
    .rdData(rdData)
  );

  assign recording = r.recording;
  assign storing = r.storing;
  assign curSeg = r.curSeg;
  assign wrPtr = r.wrPtr;
  assign sweepDone = r.sweepDone;
  assign doneSeg = r.doneSeg;
  assign trigPtr = r.trigPtr;
  assign contValid = r.contValid;
  assign contData = r.contData;
  assign standbyMode = r.standbyMode;
  assign forcePowerOff = r.forcePowerOff;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_store;
    r.storing && !cmdStop && !cmdPause && sampleTick;
  endsequence

  AST_RUN_STARTS: assert property (@(posedge sys_clk) disable iff (rst) // R01
    r.state == ST_IDLE && cmdRun |=> storing)
    else $error("run did not start storing");
  AST_STOP_ENDS: assert property (@(posedge sys_clk) disable iff (rst) // R02
    recording && cmdStop |=> !recording)
    else $error("stop did not end recording");
  AST_STANDBY: assert property (@(posedge sys_clk) disable iff (rst) // R03
    r.state == ST_IDLE && cmdPause && !cmdRun |=> !storing && !recording)
    else $error("pause from idle stored data");
  AST_HOLD_PTR: assert property (@(posedge sys_clk) disable iff (rst) // R17
    r.state == ST_HOLD && !cmdRun ##1 r.state == ST_HOLD |->
    $stable(wrPtr))
    else $error("pointer moved while paused");
  AST_RESUME: assert property (@(posedge sys_clk) disable iff (rst) // R04
    r.state == ST_HOLD && cmdRun |=> storing && $stable(curSeg))
    else $error("resume lost recording");
  AST_ADVANCE: assert property (@(posedge sys_clk) disable iff (rst) // R09
    s_store and r.state == ST_REC |=> wrPtr == $past(wrPtr) + 1'b1)
    else $error("pointer did not advance");
  AST_DONE: assert property (@(posedge sys_clk) disable iff (rst) // R18
    s_store and r.state == ST_POST and r.delayCnt <= 12'h001 |=>
    sweepDone && doneSeg == $past(curSeg))
    else $error("sweep completion missing");
  AST_CONT: assert property (@(posedge sys_clk) disable iff (rst) // R06
    s_store and storeMode == MODE_CONT |=> contValid)
    else $error("continuous sample dropped");
  AST_POWER: assert property (@(posedge sys_clk) disable iff (rst) // R14
    !standbyBtn |=> !forcePowerOff || $past(forcePowerOff))
    else $error("power off without hold");
endmodule
`default_nettype wire

// ===== hdl/sweep_rec_pkg.sv
`default_nettype none
package sweep_rec_pkg;
  localparam int SAMPLE_W = 16;
  localparam int SEG_ADDR_W = 10;
  localparam int SEG_SEL_W = 2;
  localparam int DELAY_W = 12;
  localparam int ADDR_W = SEG_ADDR_W + SEG_SEL_W;
  localparam int CLK_HZ = 20_000_000;
  localparam int HOLD_OFF_S = 4;
  localparam longint HOLD_OFF_CYC = longint'(HOLD_OFF_S) * CLK_HZ + 1;
  localparam logic [SEG_ADDR_W-1:0] PTR_RST = 10'h000;
  localparam logic [DELAY_W-1:0] DELAY_RST = 12'h000;
  typedef enum logic [1:0] {
    MODE_CONT,
    MODE_SWEEP,
    MODE_DUAL
  } store_mode_e;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_STANDBY,
    ST_REC,
    ST_HOLD,
    ST_POST
  } rec_state_e;
endpackage
`default_nettype wire

// ===== hdl/sample_mem.sv
`default_nettype none
module sample_mem #(
  parameter int DW = 16,
  parameter int AW = 12
) (
  input wire logic sys_clk,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [DW-1:0] wrData,
  input wire logic [AW-1:0] rdAddr,
  output logic [DW-1:0] rdData
);
  logic [DW-1:0] mem [2**AW];
  always_ff @(posedge sys_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule
`default_nettype wire

// ===== verif/sample_src_model.sv
`default_nettype none
module sample_src_model
  import sweep_rec_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic en,
  input wire logic sweepDone,
  output logic sampleTick,
  output logic [SAMPLE_W-1:0] sampleData,
  output logic sweepAck
);
  timeunit 1ns;
  timeprecision 1ns;
  // Converter paces one sample every other clock; codes never repeat
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sampleTick <= 1'b0;
      sampleData <= 16'h1000;
      sweepAck <= 1'b0;
    end else begin
      sampleTick <= en & ~sampleTick;
      if (en & ~sampleTick) begin
        sampleData <= sampleData + 16'h0013;
      end
      // Software collects a finished segment one clock after the flag
      sweepAck <= sweepDone & ~sweepAck;
    end
  end
endmodule
`default_nettype wire

// ===== verif/sweep_recording_control_bench.sv
`default_nettype none
module sweep_recording_control_bench;
  import sweep_rec_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, rst = 1, cmdRun = 0, cmdStop = 0, cmdPause = 0;
  logic trigger = 0, en = 0, standbyBtn = 0, sampleTick, sweepAck;
  logic recording, storing, sweepDone, contValid, standbyMode, forcePowerOff;
  logic [SAMPLE_W-1:0] sampleData, rdData, contData, first, last;
  store_mode_e storeMode = MODE_CONT;
  logic [DELAY_W-1:0] postDelay = 12'h0005;
  logic [1:0] rdSeg = 2'h0, curSeg, doneSeg;
  logic [9:0] rdAddr = 10'h000, wrPtr, trigPtr;
  int n_fail = 0, checked = 0, ticks = 0, nValid = 0;
  sweep_recording_control #(.HOLD_CYC(20)) sweep_recording_control_i (
    .sys_clk(sys_clk), .rst(rst), .cmdRun(cmdRun), .cmdStop(cmdStop),
    .cmdPause(cmdPause), .trigger(trigger), .sampleTick(sampleTick),
    .sampleData(sampleData), .storeMode(storeMode), .postDelay(postDelay),
    .rdSeg(rdSeg), .rdAddr(rdAddr), .sweepAck(sweepAck),
    .standbyBtn(standbyBtn), .recording(recording), .storing(storing),
    .curSeg(curSeg), .wrPtr(wrPtr), .sweepDone(sweepDone),
    .doneSeg(doneSeg), .trigPtr(trigPtr), .rdData(rdData),
    .contValid(contValid), .contData(contData), .standbyMode(standbyMode),
    .forcePowerOff(forcePowerOff));
  sample_src_model sample_src_model_i (.sys_clk(sys_clk), .rst(rst),
    .en(en), .sweepDone(sweepDone), .sampleTick(sampleTick),
    .sampleData(sampleData), .sweepAck(sweepAck));
  initial forever #25 sys_clk = ~sys_clk;
  // Counts ticks the bench expects to be stored; keeps first and last code
  always @(posedge sys_clk) begin
    if (sampleTick && en) begin
      if (ticks == 0) first = sampleData;
      last = sampleData;
      ticks++;
    end
    if (contValid) nValid++;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    cyc(1);
    s = 0;
    cyc(2);
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Bounded wait for the end of a sweep; running out ends the run
  task automatic waitDone(input int lim);
    int i;
    for (i = 0; i < lim && !sweepDone; i++) cyc(1);
    if (!sweepDone) begin
      n_fail++;
      end_sim();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_run_pause;
    logic [9:0] held;
    pulse(cmdRun);
    chk(storing, 1);
    ticks = 0;
    nValid = 0;
    en = 1;
    cyc(20);
    en = 0;
    cyc(2);
    chk(wrPtr, ticks);
    chk(nValid, ticks);
    chk(contData, last);
    pulse(cmdPause);
    held = wrPtr;
    chk({recording, storing}, 2'b10);
    en = 1;
    cyc(10);
    en = 0;
    cyc(2);
    chk(wrPtr, held);
    pulse(cmdRun);
    chk(storing, 1);
    pulse(trigger);
    chk(trigPtr, 16'h0000);
    chk(storing, 1);
    rdAddr = 10'h000;
    cyc(2);
    chk(rdData, first);
    pulse(cmdStop);
    chk(recording, 0);
    $display("test run_pause done");
  endtask
  task automatic t_idle_pause;
    pulse(cmdPause);
    en = 1;
    cyc(10);
    en = 0;
    cyc(2);
    chk({recording, storing, sweepDone}, 3'b000);
    chk(wrPtr, 16'h000a);
    pulse(cmdStop);
    $display("test idle_pause done");
  endtask
  task automatic t_sweep;
    storeMode = MODE_SWEEP;
    pulse(cmdRun);
    en = 1;
    cyc(8);
    pulse(trigger);
    waitDone(100);
    chk({doneSeg, curSeg, wrPtr}, 14'h0400);
    chk(trigPtr, 16'h0004);
    cyc(3);
    chk(sweepDone, 0);
    chk(recording, 1);
    pulse(cmdStop);
    en = 0;
    $display("test sweep done");
  endtask
  task automatic t_dual;
    logic [SAMPLE_W-1:0] atTrig;
    storeMode = MODE_DUAL;
    pulse(cmdRun);
    nValid = 0;
    en = 1;
    cyc(16);
    en = 0;
    cyc(2);
    atTrig = last;
    chk(nValid, 2);
    chk(contData, last);
    pulse(trigger);
    en = 1;
    waitDone(200);
    chk({doneSeg, curSeg, trigPtr}, 14'h1808);
    chk(nValid, 2);
    rdSeg = 2'h1;
    rdAddr = 10'h007;
    cyc(2);
    chk(rdData, atTrig);
    rdAddr = 10'h008;
    cyc(2);
    chk(rdData, atTrig + 16'h0013);
    pulse(cmdStop);
    en = 0;
    $display("test dual done");
  endtask
  // Delay longer than the segment: the ring wraps, only post data is left
  task automatic t_wrap;
    logic [SAMPLE_W-1:0] atDone;
    storeMode = MODE_SWEEP;
    postDelay = 12'h0401;
    pulse(cmdRun);
    en = 1;
    cyc(8);
    pulse(trigger);
    waitDone(3000);
    atDone = last;
    chk({doneSeg, trigPtr}, 12'h804);
    rdSeg = 2'h2;
    rdAddr = 10'h004;
    cyc(2);
    chk(rdData, atDone);
    rdAddr = 10'h003;
    cyc(2);
    chk(rdData, atDone - 16'h0013);
    pulse(cmdStop);
    en = 0;
    $display("test wrap done");
  endtask
  task automatic t_button;
    standbyBtn = 1;
    cyc(3);
    standbyBtn = 0;
    cyc(3);
    chk({standbyMode, forcePowerOff}, 2'b10);
    standbyBtn = 1;
    cyc(20);
    standbyBtn = 0;
    cyc(3);
    chk({standbyMode, forcePowerOff}, 2'b00);
    standbyBtn = 1;
    cyc(30);
    chk(forcePowerOff, 1);
    standbyBtn = 0;
    cyc(3);
    chk(standbyMode, 0);
    $display("test button done");
  endtask
  initial begin
    cyc(10);
    rst = 0;
    t_run_pause();
    t_idle_pause();
    t_sweep();
    t_dual();
    t_wrap();
    t_button();
    end_sim();
  end
endmodule
`default_nettype wire
